// File: verilog/uncb_pkg.sv
// Package of constants and carrier types for the USB node configuration bank
package uncb_pkg;
	// =====================================================
	// Register numbers
	localparam logic [7:0] REG_IDENT = 8'h00;
	localparam logic [7:0] REG_SETUP = 8'h04;
	localparam logic [7:0] REG_NODE_NUM = 8'h05;
	localparam logic [7:0] REG_FREQ = 8'h51;
	localparam logic [7:0] REG_LINK = 8'h80;
	// =====================================================
	// Field positions
	localparam int SETUP_LOCK_BIT = 31;
	localparam int SETUP_HDR_BIT = 0;
	localparam int NODE_NUM_W = 16;
	localparam int FREQ_W = 7;
	localparam int LINK_ERR_BIT = 27;
	localparam int LINK_GRANTED_BIT = 26;
	localparam int LINK_HELD_BIT = 25;
	localparam int LINK_CREDIT_REQUEST_GREETING_TOKEN_BIT = 24;
	localparam int LINK_RXRST_BIT = 23;
	localparam int SYM_GAP_LSB = 11;
	localparam int GAP_W = 11;
	localparam int TOK_GAP_LSB = 0;
	localparam int ID_CHIP_LSB = 24;
	localparam int ID_REV_LSB = 8;
	localparam int ID_VER_LSB = 0;
	// =====================================================
	// Reset values and limits
	localparam logic [6:0] FREQ_RESET = 7'h19;
	localparam logic [6:0] FREQ_MIN = 7'h05;
	localparam logic [6:0] FREQ_MAX = 7'h64;
	localparam logic [10:0] GAP_RESET = 11'h001;
	// =====================================================
	// Carrier types
	typedef struct packed {
		logic valid; // Request strobe, one cycle
		logic write; // One for write, zero for read
		logic [7:0] number; // Register number
		logic [31:0] wdata; // Write data
	} uncb_req_t;
	typedef struct packed {
		logic valid; // Answer strobe, one cycle
		logic ack; // One ACK, zero NACK
		logic [31:0] rdata; // Read data
	} uncb_rsp_t;
	typedef struct packed {
		logic header_one_byte; // Header format select
		logic [10:0] sym_gap; // Symbol gap minus one
		logic [10:0] tok_gap; // Token gap minus one
	} uncb_cfg_t;
endpackage

// File: verilog/uncb_resync.sv
// Two-flop synchroniser for the async status inputs
`timescale 1ns/1ps
module uncb_resync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// =====================================================
	// Elaboration check
	if (WIDTH < 1)
	begin : g_bad
		$error("uncb_resync WIDTH must be positive");
	end
	logic [WIDTH-1:0] meta_ff; // First stage, read only by second
	// Two-stage capture, clears under reset
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_ff <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule // uncb_resync

// File: verilog/uncb_bank.sv
// USB node configuration register bank, top module
`timescale 1ns/1ps
module uncb_bank #(
	parameter logic [7:0] CHIP_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0] BLOCK_REV = 8'h11, // Arbitrary value
	parameter logic [7:0] BLOCK_VER = 8'h22 // Arbitrary value
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire uncb_pkg::uncb_req_t cfg_req,
	output uncb_pkg::uncb_rsp_t cfg_rsp,
	input wire logic link_rx_error,
	input wire logic link_credit_granted,
	input wire logic link_credit_held,
	output logic link_credit_request_greeting_token_pulse,
	output logic link_rx_reset_pulse,
	output uncb_pkg::uncb_cfg_t link_cfg
);
	// =====================================================
	// Elaboration checks
	// Frequency window must be a real range
	if (uncb_pkg::FREQ_MIN > uncb_pkg::FREQ_MAX)
	begin : g_bad_freq
		$error("uncb_bank frequency limits reversed");
	end
	// Symbol gap field must stay below the strobe bits
	if (uncb_pkg::SYM_GAP_LSB + uncb_pkg::GAP_W > uncb_pkg::LINK_RXRST_BIT)
	begin : g_bad_sym
		$error("uncb_bank symbol gap overlaps strobe bits");
	end
	// Token gap field must stay below the symbol gap field
	if (uncb_pkg::TOK_GAP_LSB + uncb_pkg::GAP_W > uncb_pkg::SYM_GAP_LSB)
	begin : g_bad_tok
		$error("uncb_bank token gap overlaps symbol gap");
	end
	// Frequency field must leave upper bits for the range check
	if (uncb_pkg::FREQ_W >= 32)
	begin : g_bad_fw
		$error("uncb_bank frequency field too wide");
	end
	// =====================================================
	// Reset release
	logic rst_meta_ff; // First reset stage, read only by the second
	logic rst_sync_n_ff; // Second reset stage, active low
	logic rst_sync_n; // Synchronised reset used by the whole bank
	logic [2:0] stat_sync; // Synchronised status: error, granted, held
	// Release waits two edges so no flop leaves reset on a runt edge
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_ff <= 1'h0;
			rst_sync_n_ff <= 1'h0;
		end
		else
		begin
			rst_meta_ff <= 1'h1;
			rst_sync_n_ff <= rst_meta_ff;
		end
	end
	// Reset copy handed to every other process
	assign rst_sync_n = rst_sync_n_ff;
	// Status lines come from the link side, so two flops come first
	uncb_resync #(
		.WIDTH(3)
	) u_stat_sync (
		.core_clk(core_clk),
		.resetn(rst_sync_n),
		.async_in({link_rx_error, link_credit_granted, link_credit_held}),
		.sync_out(stat_sync)
	);
	// =====================================================
	// Register state
	logic lock_ff; // Update lock
	logic hdr_ff; // Header format
	logic [15:0] node_num_ff; // Compatibility node number
	logic [6:0] freq_ff; // Frequency in MHz
	logic [10:0] sym_gap_ff; // Symbol gap minus one
	logic [10:0] tok_gap_ff; // Token gap minus one
	logic credit_request_greeting_token_ff; // Greeting strobe
	logic rxrst_ff; // Receiver reset strobe
	uncb_pkg::uncb_rsp_t rsp_ff; // Answer register
	// =====================================================
	// Decode helpers
	// True when a request names the given register number
	function automatic logic reg_hit(input logic [7:0] number, input logic [7:0] code);
		reg_hit = (number == code);
	endfunction
	// Identity word, reserved byte left at zero
	function automatic logic [31:0] ident_word(
		input logic [7:0] chip,
		input logic [7:0] rev,
		input logic [7:0] ver
	);
		logic [31:0] word;
		word = 32'h0;
		word[uncb_pkg::ID_CHIP_LSB +: 8] = chip;
		word[uncb_pkg::ID_REV_LSB +: 8] = rev;
		word[uncb_pkg::ID_VER_LSB +: 8] = ver;
		return word;
	endfunction
	// Setup word, all reserved bits zero
	function automatic logic [31:0] setup_word(input logic lock, input logic hdr);
		logic [31:0] word;
		word = 32'h0;
		word[uncb_pkg::SETUP_LOCK_BIT] = lock;
		word[uncb_pkg::SETUP_HDR_BIT] = hdr;
		return word;
	endfunction
	// Link word from live status and gaps; strobe bits stay zero
	function automatic logic [31:0] link_word(
		input logic [2:0] stat,
		input logic [10:0] sym,
		input logic [10:0] tok
	);
		logic [31:0] word;
		word = 32'h0;
		word[uncb_pkg::LINK_ERR_BIT] = stat[2];
		word[uncb_pkg::LINK_GRANTED_BIT] = stat[1];
		word[uncb_pkg::LINK_HELD_BIT] = stat[0];
		word[uncb_pkg::SYM_GAP_LSB +: uncb_pkg::GAP_W] = sym;
		word[uncb_pkg::TOK_GAP_LSB +: uncb_pkg::GAP_W] = tok;
		return word;
	endfunction
	// =====================================================
	// Decode
	wire wr = cfg_req.valid && cfg_req.write; // Write request
	wire [31:0] wd = cfg_req.wdata; // Write data
	wire hit_ident = reg_hit(cfg_req.number, uncb_pkg::REG_IDENT);
	wire hit_setup = reg_hit(cfg_req.number, uncb_pkg::REG_SETUP);
	wire hit_node = reg_hit(cfg_req.number, uncb_pkg::REG_NODE_NUM);
	wire hit_freq = reg_hit(cfg_req.number, uncb_pkg::REG_FREQ);
	wire hit_link = reg_hit(cfg_req.number, uncb_pkg::REG_LINK);
	// Any of the five numbers; all others are refused
	wire mapped = hit_ident || hit_setup || hit_node || hit_freq || hit_link;
	wire [6:0] wfreq = wd[uncb_pkg::FREQ_W-1:0]; // Proposed frequency
	wire freq_ok = (wd[31:uncb_pkg::FREQ_W] == '0) && (wfreq >= uncb_pkg::FREQ_MIN)
		&& (wfreq <= uncb_pkg::FREQ_MAX);
	wire wr_setup = wr && hit_setup && !lock_ff;
	wire wr_link = wr && hit_link && !lock_ff;
	wire wr_node = wr && hit_node;
	wire wr_freq = wr && hit_freq && freq_ok;
	// NACK on unmapped or rejected frequency write
	wire ack = mapped && !(wr && hit_freq && !freq_ok);
	// =====================================================
	// Read data selection
	wire [31:0] rd_ident = ident_word(CHIP_CODE, BLOCK_REV, BLOCK_VER);
	wire [31:0] rd_setup = setup_word(lock_ff, hdr_ff);
	wire [31:0] rd_node = {16'h0, node_num_ff};
	wire [31:0] rd_freq = {25'h0, freq_ff};
	// Strobe bits read as zero, status is live after the synchroniser
	wire [31:0] rd_link = link_word(stat_sync, sym_gap_ff, tok_gap_ff);
	// Unmapped numbers read as zero
	wire [31:0] rd_sel = hit_ident ? rd_ident :
		hit_setup ? rd_setup :
		hit_node ? rd_node :
		hit_freq ? rd_freq :
		hit_link ? rd_link : 32'h0;
	// =====================================================
	// Setup register: lock is sticky until reset
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			lock_ff <= 1'h0;
			hdr_ff <= 1'h0;
		end
		// Once locked, wr_setup stays low until reset
		else if (wr_setup)
		begin
			lock_ff <= wd[uncb_pkg::SETUP_LOCK_BIT];
			hdr_ff <= wd[uncb_pkg::SETUP_HDR_BIT];
		end
	end
	// Node number and frequency
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			node_num_ff <= 16'h0;
			freq_ff <= uncb_pkg::FREQ_RESET;
		end
		else
		begin
			// Node number is never locked
			if (wr_node)
				node_num_ff <= wd[uncb_pkg::NODE_NUM_W-1:0];
			// Out-of-range values never reach the field
			if (wr_freq)
				freq_ff <= wfreq;
		end
	end
	// Link gaps and single-cycle strobes
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			sym_gap_ff <= uncb_pkg::GAP_RESET;
			tok_gap_ff <= uncb_pkg::GAP_RESET;
			credit_request_greeting_token_ff <= 1'h0;
			rxrst_ff <= 1'h0;
		end
		else
		begin
			// Strobes follow each unlocked link write that sets their bit, for one cycle only
			credit_request_greeting_token_ff <= wr_link && wd[uncb_pkg::LINK_CREDIT_REQUEST_GREETING_TOKEN_BIT];
			rxrst_ff <= wr_link && wd[uncb_pkg::LINK_RXRST_BIT];
			if (wr_link)
			begin
				sym_gap_ff <= wd[uncb_pkg::SYM_GAP_LSB +: uncb_pkg::GAP_W];
				tok_gap_ff <= wd[uncb_pkg::TOK_GAP_LSB +: uncb_pkg::GAP_W];
			end
		end
	end
	// Answer register, one cycle after request
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			rsp_ff <= '0;
		else
		begin
			// Every request gets one answer; writes return zero data
			rsp_ff.valid <= cfg_req.valid;
			rsp_ff.ack <= cfg_req.valid && ack;
			rsp_ff.rdata <= (cfg_req.valid && !cfg_req.write) ? rd_sel : 32'h0;
		end
	end
	// =====================================================
	// Outputs
	assign cfg_rsp = rsp_ff;
	assign link_credit_request_greeting_token_pulse = credit_request_greeting_token_ff;
	assign link_rx_reset_pulse = rxrst_ff;
	assign link_cfg = '{header_one_byte: hdr_ff, sym_gap: sym_gap_ff, tok_gap: tok_gap_ff};
endmodule // uncb_bank

// File: verif/uncb_checker.sv
// Port checker for the configuration bank
`timescale 1ns/1ps
module uncb_checker (
	input wire logic core_clk,
	input wire logic resetn,
	input wire uncb_pkg::uncb_req_t cfg_req,
	input wire uncb_pkg::uncb_rsp_t cfg_rsp,
	input wire logic link_credit_request_greeting_token_pulse,
	input wire logic link_rx_reset_pulse,
	input wire uncb_pkg::uncb_cfg_t link_cfg
);
	// ==========
	// Request decode
	wire logic [7:0] n = cfg_req.number; // Register number
	wire logic [31:0] d = cfg_req.wdata; // Write data
	wire logic wr = cfg_req.valid && cfg_req.write; // Write request
	wire logic hel = wr && n == 8'h80 && d[24]; // Greeting strobe asked
	wire logic rxr = wr && n == 8'h80 && d[23]; // Receiver reset asked
	wire logic mapped = n inside {8'h00, 8'h04, 8'h05, 8'h51, 8'h80};
	logic lock_seen_ff; // Lock bit written since reset
	// Helper: lock taken once written, held until reset
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			lock_seen_ff <= 1'h0;
		else if (wr && n == 8'h04 && d[31])
			lock_seen_ff <= 1'h1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// ==========
	// Properties
	a_rsp_follows: assert property (cfg_req.valid |=> cfg_rsp.valid)
		else $error("answer missing");
	a_rsp_only: assert property (!cfg_req.valid |=> !cfg_rsp.valid)
		else $error("answer without request");
	a_unmapped_nack: assert property (cfg_req.valid && !mapped |=>
		!cfg_rsp.ack && cfg_rsp.rdata == 32'h0) else $error("unmapped not refused");
	a_freq_nack: assert property (wr && n == 8'h51 && (d < 32'h5 || d > 32'h64)
		|=> !cfg_rsp.ack) else $error("bad frequency accepted");
	a_credit_request_greeting_token_cause: assert property (link_credit_request_greeting_token_pulse |-> $past(hel) && cfg_rsp.ack)
		else $error("greeting pulse without write");
	a_rxrst_cause: assert property (link_rx_reset_pulse |-> $past(rxr))
		else $error("receiver reset without write");
	a_cfg_hold: assert property ($changed(link_cfg) |-> cfg_rsp.valid && cfg_rsp.ack)
		else $error("link settings moved alone");
	a_ident_rsvd: assert property (cfg_req.valid && n == 8'h00 && !cfg_req.write
		|=> cfg_rsp.rdata[23:16] == 8'h0) else $error("identity reserved nonzero");
	a_freq_ack: assert property (wr && n == 8'h51 && d >= 32'h5 && d <= 32'h64 |=>
		cfg_rsp.ack) else $error("good frequency refused");
	a_lock_credit_request_greeting_token: assert property (lock_seen_ff && hel |=> !link_credit_request_greeting_token_pulse)
		else $error("greeting pulse while locked");
	a_lock_cfg: assert property (lock_seen_ff |=> $stable(link_cfg))
		else $error("link settings moved while locked");
endmodule // uncb_checker
bind uncb_bank uncb_checker u_chk (.core_clk, .resetn, .cfg_req, .cfg_rsp,
	.link_credit_request_greeting_token_pulse, .link_rx_reset_pulse, .link_cfg);

// File: verif/uncb_link_model.sv
// Remote link end, seen through its status lines
`timescale 1ns/1ps
module uncb_link_model (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic credit_request_greeting_token,
	input wire logic rx_rst,
	input wire logic inject_err,
	input wire logic give,
	output logic rx_error,
	output logic granted,
	output logic held
);
	// Credit and error state of the far end
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			{rx_error, granted, held} <= 3'h0;
		else
		begin
			granted <= 1'h1;
			held <= give | (held & ~credit_request_greeting_token);
			rx_error <= inject_err | (rx_error & ~rx_rst);
		end
	end
endmodule // uncb_link_model

// File: verif/tb.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
module tb;
	logic core_clk = 1'h0;
	logic resetn = 1'h0;
	uncb_pkg::uncb_req_t cfg_req = '0;
	uncb_pkg::uncb_rsp_t cfg_rsp;
	uncb_pkg::uncb_cfg_t link_cfg;
	logic rx_err, granted, held, credit_request_greeting_token, rx_rst;
	logic inject_err = 1'h0;
	logic give = 1'h0;
	logic [31:0] fv [5] = '{32'h4, 32'h65, 32'h5, 32'h64, 32'h80000010};
	logic [4:0] fa = 5'h0c; // Expected ack per frequency
	int n_fail = 0;
	int n_checks = 0;
	int t = 0;
	uncb_bank u_dut (.core_clk, .resetn, .cfg_req, .cfg_rsp, .link_rx_error(rx_err),
		.link_credit_granted(granted), .link_credit_held(held),
		.link_credit_request_greeting_token_pulse(credit_request_greeting_token), .link_rx_reset_pulse(rx_rst), .link_cfg);
	uncb_link_model u_far (.core_clk, .resetn, .credit_request_greeting_token, .rx_rst, .inject_err, .give,
		.rx_error(rx_err), .granted, .held);
	initial forever #5 core_clk = ~core_clk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input logic [7:0] r);
		n_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("MISMATCH reg %h exp %h seen %h", r, e, s);
		end
	endtask
	// One request after an idle edge, answer checked in the next cycle
	task automatic acc(input logic w, input logic [7:0] r, input logic [31:0] d,
		input logic a, input logic [31:0] e);
		@(negedge core_clk);
		cfg_req = '{1'h1, w, r, d};
		@(negedge core_clk);
		cfg_req.valid = 1'h0;
		chk({30'h0, cfg_rsp.valid, cfg_rsp.ack}, {30'h0, 1'h1, a}, r);
		chk(cfg_rsp.rdata, w ? 32'h0 : e, r);
	endtask
	task automatic idle(input int c);
		repeat (c) @(negedge core_clk);
	endtask
	task automatic done;
		t++;
		$display("test %0d done", t);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Watchdog against a hang
	initial
	begin
		#100000;
		n_fail++;
		tally_and_finish;
	end
	initial
	begin
		idle(6);
		resetn = 1'h1;
		idle(4);
		acc(1'h0, 8'h00, 32'h0, 1'h1, 32'h5a001122);
		acc(1'h0, 8'h04, 32'h0, 1'h1, 32'h0);
		acc(1'h0, 8'h51, 32'h0, 1'h1, 32'h19);
		acc(1'h1, 8'h51, 32'h64, 1'h1, 32'h0);
		acc(1'h0, 8'h80, 32'h0, 1'h1, 32'h04000801);
		acc(1'h0, 8'h06, 32'h0, 1'h0, 32'h0);
		acc(1'h1, 8'h00, 32'hffffffff, 1'h1, 32'h0);
		acc(1'h0, 8'h00, 32'h0, 1'h1, 32'h5a001122);
		done;
		foreach (fv[i])
			acc(1'h1, 8'h51, fv[i], fa[i], 32'h0);
		acc(1'h0, 8'h51, 32'h0, 1'h1, 32'h64);
		acc(1'h1, 8'h05, 32'hffffffff, 1'h1, 32'h0);
		acc(1'h0, 8'h05, 32'h0, 1'h1, 32'hffff);
		done;
		give = 1'h1;
		idle(4);
		give = 1'h0;
		acc(1'h0, 8'h80, 32'h0, 1'h1, 32'h06000801);
		acc(1'h1, 8'h80, 32'h01001807, 1'h1, 32'h0);
		chk({31'h0, credit_request_greeting_token}, 32'h1, 8'h80);
		chk({9'h0, link_cfg}, 32'h1807, 8'h80);
		inject_err = 1'h1;
		idle(4);
		inject_err = 1'h0;
		chk({31'h0, credit_request_greeting_token}, 32'h0, 8'h80);
		acc(1'h0, 8'h80, 32'h0, 1'h1, 32'h0c001807);
		acc(1'h1, 8'h80, 32'h00801807, 1'h1, 32'h0);
		chk({31'h0, rx_rst}, 32'h1, 8'h80);
		idle(4);
		chk({31'h0, rx_rst}, 32'h0, 8'h80);
		acc(1'h0, 8'h80, 32'h0, 1'h1, 32'h04001807);
		done;
		acc(1'h1, 8'h04, 32'h80000001, 1'h1, 32'h0);
		chk({9'h0, link_cfg}, 32'h401807, 8'h04);
		acc(1'h1, 8'h04, 32'h0, 1'h1, 32'h0);
		acc(1'h0, 8'h04, 32'h0, 1'h1, 32'h80000001);
		acc(1'h1, 8'h80, 32'h01000000, 1'h1, 32'h0);
		chk({31'h0, credit_request_greeting_token}, 32'h0, 8'h80);
		acc(1'h0, 8'h80, 32'h0, 1'h1, 32'h04001807);
		done;
		// Mid-run reset clears lock and restores every field
		resetn = 1'h0;
		idle(2);
		resetn = 1'h1;
		idle(4);
		acc(1'h0, 8'h04, 32'h0, 1'h1, 32'h0);
		acc(1'h0, 8'h05, 32'h0, 1'h1, 32'h0);
		acc(1'h0, 8'h51, 32'h0, 1'h1, 32'h19);
		acc(1'h0, 8'h80, 32'h0, 1'h1, 32'h04000801);
		done;
		tally_and_finish;
	end
endmodule // tb
